// >>> rtl/spcs_pkg.sv
// Shared constants and types of the serial port control and status block.
// Assumes a 10 MHz APB clock and registers of up to 16 bits (the baud divisor) held in 32-bit words.
`default_nettype none
package spcs_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] TXCS_OFFSET = 8'h00;
  localparam logic [7:0] RXCS_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;
  localparam logic [7:0] BAUD_OFFSET = 8'h0c;
  localparam logic [7:0] AUX_OFFSET = 8'h10;
  // ==========================================================================
  // Field positions
  localparam int CLK_SRC_BIT = 7;
  localparam int TX9_BIT = 6;
  localparam int TRANSMIT_ENABLE_BIT = 5;
  localparam int SYNC_BIT = 4;
  localparam int BRK_BIT = 3;
  localparam int HBS_BIT = 2;
  localparam int TSRE_BIT = 1;
  localparam int TRANSMIT_NINTH_BIT_BIT = 0;
  localparam int PORT_ENABLE_BIT = 7;
  localparam int RX9_BIT = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int ADDEN_BIT = 3;
  localparam int FRAMING_ERROR_FLAG_BIT = 2;
  localparam int OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int RECEIVE_NINTH_BIT_BIT = 0;
  localparam int POL_BIT = 0;
  localparam int THE_BIT = 1;
  localparam int RBF_BIT = 2;
  // ==========================================================================
  // Values after reset
  localparam logic [7:0] TXCS_RESET = 8'h02;
  localparam logic [7:0] RXCS_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  // ==========================================================================
  // Counts of baud ticks and frame bits
  localparam logic [6:0] BIT_TICKS_LOW = 7'h40;
  localparam logic [6:0] BIT_TICKS_HIGH = 7'h10;
  localparam logic [1:0] SYNC_HALF_TICKS = 2'h2;
  localparam logic [3:0] BREAK_BITS = 4'hc;
  localparam logic [3:0] ASYNC8_BITS = 4'ha;
  localparam logic [3:0] ASYNC9_BITS = 4'hb;
  localparam logic [3:0] DATA8_BITS = 4'h8;
  localparam logic [3:0] DATA9_BITS = 4'h9;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic o;
    logic oe;
  } spcs_pin_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } spcs_rx_state_type;
  // Last tick index of one asynchronous bit time.
  function automatic logic [6:0] spcs_bit_last(input logic hbs);
    return hbs ? BIT_TICKS_HIGH - 7'h01 : BIT_TICKS_LOW - 7'h01;
  endfunction
  // Data bits of one character, with the ninth bit when selected.
  function automatic logic [3:0] spcs_data_bits(input logic nine);
    return nine ? DATA9_BITS : DATA8_BITS;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/spcs_sync.sv
// Three-stage pin synchroniser whose output changes once stages two and three agree.
// Assumes the input is asynchronous to pclk.
`default_nettype none
module spcs_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and clean level
  input wire logic pin_in,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  // ==========================================================================
  // Chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      level_ff <= INIT;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end
  assign level = level_ff;
endmodule // spcs_sync
`default_nettype wire

// >>> rtl/spcs_baud.sv
// Baud tick divider: one-cycle pulse every div+1 clocks.
// Assumes clear is raised whenever the divisor is rewritten.
`default_nettype none
module spcs_baud #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic [W-1:0] div,
  // Tick
  output logic tick
);
  logic [W-1:0] cnt_ff;
  logic tick_ff;
  // ==========================================================================
  // Counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (clear) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= div) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end
  assign tick = tick_ff;
endmodule // spcs_baud
`default_nettype wire

// >>> rtl/spcs_top.sv
// Transmit and receive control and status logic of a serial port, APB slave.
// Assumes a single 10 MHz pclk; pins are resolved outside from out and enable.
//
// Added by the designer: the register addresses and the APB slave port.
`default_nettype none
module spcs_top #(
  parameter int unsigned DIV_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic transmit_clock_pin_in,
  input wire logic receive_data_pin_in,
  output spcs_pkg::spcs_pin_type transmit_clock_pin,
  output spcs_pkg::spcs_pin_type receive_data_pin
);
  import spcs_pkg::*;

  if (DIV_W < 8 || DIV_W > 16) begin : g_chk
    $error("spcs_top: DIV_W must lie between 8 and 16.");
  end

  logic clock_source_select_ff, transmit_nine_bit_select_ff, transmit_enable_ff;
  logic sync_mode_ff, break_request_ff, high_baud_speed_ff, transmit_ninth_bit_ff;
  logic port_enable_ff, receive_nine_bit_select_ff, single_receive_enable_ff;
  logic continuous_receive_enable_ff, address_detect_ff;
  logic framing_error_flag_ff, overrun_error_flag_ff, receive_ninth_bit_ff;
  logic clock_polarity_ff;
  logic [DIV_W-1:0] baud_div_ff;
  logic [7:0] tx_hold_ff, receive_buffer_ff;
  logic tx_hold_full_ff, rx_full_ff;
  logic [12:0] tx_sr_ff;
  logic [3:0] tx_left_ff, rx_left_ff;
  logic [6:0] tx_tick_ff, rx_tick_ff;
  logic brk_sending_ff;
  logic [8:0] rx_sr_ff;
  spcs_rx_state_type rx_state_ff;
  logic sclk_phase_ff, sclk_prev_ff;
  logic [1:0] half_cnt_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  spcs_pin_type tx_pin_ff, rx_pin_ff;
  logic acc, wr_txcs, wr_rxcs, wr_data, wr_baud, rd_data, tick, din, clk_lvl;
  logic master, tx_busy, rx_want, running, m_step, lead, trail, tx_load, tx_shift;
  logic rx_go, bit_end, half_end, dlv, dlv_framing_error_flag;
  logic [6:0] last;
  logic [8:0] dlv_word;
  logic [7:0] txcs_val, rxcs_val;

  // ==========================================================================
  // Bus decode
  assign acc = psel && penable && pready_ff;
  assign wr_txcs = acc && pwrite && paddr == TXCS_OFFSET;
  assign wr_rxcs = acc && pwrite && paddr == RXCS_OFFSET;
  assign wr_data = acc && pwrite && paddr == DATA_OFFSET;
  assign wr_baud = acc && pwrite && paddr == BAUD_OFFSET;
  assign rd_data = acc && !pwrite && paddr == DATA_OFFSET;

  // ==========================================================================
  // Pin synchronisers and baud ticks
  spcs_sync #(.INIT(1'b1)) u_rx_sync (
    .pclk(pclk), .presetn(presetn), .pin_in(receive_data_pin_in), .level(din)
  );
  spcs_sync #(.INIT(1'b0)) u_ck_sync (
    .pclk(pclk), .presetn(presetn), .pin_in(transmit_clock_pin_in), .level(clk_lvl)
  );
  spcs_baud #(.W(DIV_W)) u_baud (
    .pclk(pclk), .presetn(presetn), .clear(wr_baud || !port_enable_ff),
    .div(baud_div_ff), .tick(tick)
  );

  // ==========================================================================
  // Mode and event terms
  assign master = sync_mode_ff && clock_source_select_ff;
  assign tx_busy = tx_left_ff != 4'h0;
  assign rx_want = continuous_receive_enable_ff || (single_receive_enable_ff && master);
  assign running = port_enable_ff && master && (tx_busy || rx_want);
  assign m_step = running && tick && half_cnt_ff == SYNC_HALF_TICKS - 2'h1;
  // Slave edges come from the clean clock level; idle level is the polarity bit.
  always_comb begin
    if (master) begin
      lead = m_step && !sclk_phase_ff;
      trail = m_step && sclk_phase_ff;
    end else begin
      lead = sync_mode_ff && clk_lvl != sclk_prev_ff && clk_lvl != clock_polarity_ff;
      trail = sync_mode_ff && clk_lvl != sclk_prev_ff && clk_lvl == clock_polarity_ff;
    end
  end
  assign last = spcs_bit_last(high_baud_speed_ff);
  assign bit_end = tick && rx_tick_ff == last;
  assign half_end = tick && rx_tick_ff == {1'b0, last[6:1]};
  // Receiving in sync half duplex keeps the transmitter from starting.
  assign tx_load = port_enable_ff && transmit_enable_ff && tx_hold_full_ff && !tx_busy
                   && !(sync_mode_ff && rx_want);
  assign tx_shift = tx_busy && (sync_mode_ff ? trail
                    : (tick && tx_tick_ff == last));
  assign rx_go = sync_mode_ff && port_enable_ff && rx_want && !tx_busy;

  // ==========================================================================
  // Received character delivery
  always_comb begin
    dlv = 1'b0;
    dlv_framing_error_flag = 1'b0;
    dlv_word = sync_mode_ff ? {din, rx_sr_ff[8:1]} : rx_sr_ff;
    if (sync_mode_ff && rx_go && lead && rx_left_ff == 4'h1) begin
      dlv = 1'b1;
    end
    if (!sync_mode_ff && rx_state_ff == RX_STOP && bit_end) begin
      dlv = 1'b1;
      dlv_framing_error_flag = !din;
    end
  end

  // ==========================================================================
  // Transmit control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clock_source_select_ff, transmit_nine_bit_select_ff, transmit_enable_ff,
       sync_mode_ff, break_request_ff, high_baud_speed_ff} <= TXCS_RESET[7:2];
      transmit_ninth_bit_ff <= TXCS_RESET[TRANSMIT_NINTH_BIT_BIT];
    end else if (wr_txcs) begin
      clock_source_select_ff <= pwdata[CLK_SRC_BIT];
      transmit_nine_bit_select_ff <= pwdata[TX9_BIT];
      transmit_enable_ff <= pwdata[TRANSMIT_ENABLE_BIT];
      sync_mode_ff <= pwdata[SYNC_BIT];
      break_request_ff <= pwdata[BRK_BIT];
      high_baud_speed_ff <= pwdata[HBS_BIT];
      transmit_ninth_bit_ff <= pwdata[TRANSMIT_NINTH_BIT_BIT];
    end else if (tx_shift && brk_sending_ff && tx_left_ff == 4'h1) begin
      break_request_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Receive control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {port_enable_ff, receive_nine_bit_select_ff, single_receive_enable_ff,
       continuous_receive_enable_ff, address_detect_ff} <= RXCS_RESET[7:3];
    end else if (wr_rxcs) begin
      port_enable_ff <= pwdata[PORT_ENABLE_BIT];
      receive_nine_bit_select_ff <= pwdata[RX9_BIT];
      single_receive_enable_ff <= pwdata[SINGLE_RECEIVE_ENABLE_BIT];
      continuous_receive_enable_ff <= pwdata[CONTINUOUS_RECEIVE_ENABLE_BIT];
      address_detect_ff <= pwdata[ADDEN_BIT];
    end else if (dlv && sync_mode_ff && !continuous_receive_enable_ff) begin
      single_receive_enable_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Baud divisor, polarity and transmit holding word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_div_ff <= BAUD_RESET[DIV_W-1:0];
      clock_polarity_ff <= 1'b0;
    end else begin
      if (wr_baud) baud_div_ff <= pwdata[DIV_W-1:0];
      if (acc && pwrite && paddr == AUX_OFFSET) clock_polarity_ff <= pwdata[POL_BIT];
    end
  end
  // A write while the holding word is still pending replaces it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_ff <= 8'h00;
      tx_hold_full_ff <= 1'b0;
    end else if (wr_data) begin
      tx_hold_ff <= pwdata[7:0];
      tx_hold_full_ff <= 1'b1;
    end else if (tx_load || !port_enable_ff) begin
      tx_hold_full_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Transmit shift register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sr_ff <= 13'h1fff;
      tx_left_ff <= 4'h0;
      tx_tick_ff <= 7'h00;
      brk_sending_ff <= 1'b0;
    end else if (!port_enable_ff) begin
      tx_sr_ff <= 13'h1fff;
      tx_left_ff <= 4'h0;
      tx_tick_ff <= 7'h00;
      brk_sending_ff <= 1'b0;
    end else if (tx_load) begin
      tx_tick_ff <= 7'h00;
      brk_sending_ff <= !sync_mode_ff && break_request_ff;
      if (sync_mode_ff) begin
        tx_sr_ff <= {4'hf, transmit_ninth_bit_ff, tx_hold_ff};
        tx_left_ff <= spcs_data_bits(transmit_nine_bit_select_ff);
      end else if (break_request_ff) begin
        tx_sr_ff <= 13'h1000;
        tx_left_ff <= BREAK_BITS + 4'h1;
      end else begin
        tx_sr_ff <= {3'b111, transmit_nine_bit_select_ff ? transmit_ninth_bit_ff : 1'b1,
                     tx_hold_ff, 1'b0};
        tx_left_ff <= transmit_nine_bit_select_ff ? ASYNC9_BITS : ASYNC8_BITS;
      end
    end else if (tx_shift) begin
      tx_sr_ff <= {1'b1, tx_sr_ff[12:1]};
      tx_left_ff <= tx_left_ff - 4'h1;
      tx_tick_ff <= 7'h00;
    end else if (tx_busy && !sync_mode_ff && tick) begin
      tx_tick_ff <= tx_tick_ff + 7'h01;
    end
  end

  // ==========================================================================
  // Synchronous clock generation and slave edge tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_phase_ff <= 1'b0;
      half_cnt_ff <= 2'h0;
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= clk_lvl;
      if (!running) begin
        sclk_phase_ff <= 1'b0;
        half_cnt_ff <= 2'h0;
      end else if (m_step) begin
        sclk_phase_ff <= !sclk_phase_ff;
        half_cnt_ff <= 2'h0;
      end else if (tick) begin
        half_cnt_ff <= half_cnt_ff + 2'h1;
      end
    end
  end

  // ==========================================================================
  // Receive shifter and asynchronous receive sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_ff <= RX_IDLE;
      rx_sr_ff <= 9'h000;
      rx_left_ff <= 4'h0;
      rx_tick_ff <= 7'h00;
    end else if (!port_enable_ff) begin
      rx_state_ff <= RX_IDLE;
      rx_left_ff <= 4'h0;
      rx_tick_ff <= 7'h00;
    end else if (sync_mode_ff) begin
      rx_state_ff <= RX_IDLE;
      if (!rx_go) begin
        rx_left_ff <= 4'h0;
      end else if (rx_left_ff == 4'h0) begin
        rx_left_ff <= spcs_data_bits(receive_nine_bit_select_ff);
      end else if (lead) begin
        rx_sr_ff <= {din, rx_sr_ff[8:1]};
        rx_left_ff <= rx_left_ff - 4'h1;
      end
    end else if (!continuous_receive_enable_ff) begin
      rx_state_ff <= RX_IDLE;
      rx_tick_ff <= 7'h00;
    end else begin
      case (rx_state_ff)
        RX_IDLE: begin
          rx_tick_ff <= 7'h00;
          if (!din) rx_state_ff <= RX_START;
        end
        RX_START: begin
          if (half_end) begin
            rx_tick_ff <= 7'h00;
            rx_left_ff <= spcs_data_bits(receive_nine_bit_select_ff);
            rx_state_ff <= din ? RX_IDLE : RX_DATA;
          end else if (tick) begin
            rx_tick_ff <= rx_tick_ff + 7'h01;
          end
        end
        RX_DATA: begin
          if (bit_end) begin
            rx_tick_ff <= 7'h00;
            rx_sr_ff <= {din, rx_sr_ff[8:1]};
            rx_left_ff <= rx_left_ff - 4'h1;
            if (rx_left_ff == 4'h1) rx_state_ff <= RX_STOP;
          end else if (tick) begin
            rx_tick_ff <= rx_tick_ff + 7'h01;
          end
        end
        RX_STOP: begin
          if (bit_end) begin
            rx_tick_ff <= 7'h00;
            rx_state_ff <= RX_IDLE;
          end else if (tick) begin
            rx_tick_ff <= rx_tick_ff + 7'h01;
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Receive buffer and error flags
  // An overrun drops the new character; reception resumes once the flag clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer_ff <= 8'h00;
      receive_ninth_bit_ff <= 1'b0;
      framing_error_flag_ff <= 1'b0;
      overrun_error_flag_ff <= 1'b0;
      rx_full_ff <= 1'b0;
    end else if (!port_enable_ff) begin
      framing_error_flag_ff <= 1'b0;
      overrun_error_flag_ff <= 1'b0;
      rx_full_ff <= 1'b0;
    end else begin
      if (dlv && (rx_full_ff || overrun_error_flag_ff)) begin
        overrun_error_flag_ff <= 1'b1;
      end else if (wr_rxcs && !pwdata[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
        overrun_error_flag_ff <= 1'b0;
      end
      if (dlv && !rx_full_ff && !overrun_error_flag_ff) begin
        receive_buffer_ff <= receive_nine_bit_select_ff ? dlv_word[7:0] : dlv_word[8:1];
        receive_ninth_bit_ff <= receive_nine_bit_select_ff && dlv_word[8];
        framing_error_flag_ff <= dlv_framing_error_flag;
        rx_full_ff <= 1'b1;
      end else if (rd_data) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_ff <= '{o: 1'b1, oe: 1'b0};
      rx_pin_ff <= '{o: 1'b1, oe: 1'b0};
    end else if (!port_enable_ff) begin
      tx_pin_ff <= '{o: 1'b1, oe: 1'b0};
      rx_pin_ff <= '{o: 1'b1, oe: 1'b0};
    end else if (!sync_mode_ff) begin
      tx_pin_ff <= '{o: tx_busy ? tx_sr_ff[0] : 1'b1, oe: 1'b1};
      rx_pin_ff <= '{o: 1'b1, oe: 1'b0};
    end else begin
      tx_pin_ff <= '{o: sclk_phase_ff ^ clock_polarity_ff, oe: master};
      rx_pin_ff <= '{o: tx_busy ? tx_sr_ff[0] : 1'b1, oe: tx_busy};
    end
  end

  // ==========================================================================
  // APB read data, captured in the setup cycle
  assign txcs_val = {clock_source_select_ff, transmit_nine_bit_select_ff, transmit_enable_ff,
                     sync_mode_ff, break_request_ff, high_baud_speed_ff, !tx_busy,
                     transmit_ninth_bit_ff};
  assign rxcs_val = {port_enable_ff, receive_nine_bit_select_ff, single_receive_enable_ff,
                     continuous_receive_enable_ff, address_detect_ff, framing_error_flag_ff,
                     overrun_error_flag_ff, receive_ninth_bit_ff};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= 1'b1;
      if (psel && !penable) begin
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h00000000;
        case (paddr)
          TXCS_OFFSET: prdata_ff[7:0] <= txcs_val;
          RXCS_OFFSET: prdata_ff[7:0] <= rxcs_val;
          DATA_OFFSET: prdata_ff[7:0] <= receive_buffer_ff;
          BAUD_OFFSET: prdata_ff[DIV_W-1:0] <= baud_div_ff;
          AUX_OFFSET: prdata_ff[2:0] <= {rx_full_ff, !tx_hold_full_ff, clock_polarity_ff};
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign transmit_clock_pin = tx_pin_ff;
  assign receive_data_pin = rx_pin_ff;
endmodule // spcs_top
`default_nettype wire

// >>> sim/spcs_sva.sv
// Checker of the serial port control block, bound to its top.
// Assumes port enable and link mode change only by APB writes.
`default_nettype none
module spcs_sva
  import spcs_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire spcs_pkg::spcs_pin_type transmit_clock_pin,
  input wire spcs_pkg::spcs_pin_type receive_data_pin
);
  logic en_ff;
  logic sync_ff;
  wire wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_ff <= 1'b0;
    else if (wr && paddr == RXCS_OFFSET) en_ff <= pwdata[PORT_ENABLE_BIT];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sync_ff <= 1'b0;
    else if (wr && paddr == TXCS_OFFSET) sync_ff <= pwdata[SYNC_BIT];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && !penable ##1 psel && penable;
  endsequence
  AST_READY: assert property ($past(presetn) |-> pready) else $error("pready low");
  AST_SLVERR: assert property (s_acc ##0 paddr > AUX_OFFSET |-> pslverr) else $error("no slverr");
  AST_UPPER: assert property (s_acc |-> prdata[31:16] == 16'h0 &&
    (paddr == BAUD_OFFSET || prdata[15:8] == 8'h00)) else $error("upper read bits set");
  AST_TX_MAP: assert property (s_acc ##0 paddr == TXCS_OFFSET |-> !pslverr)
    else $error("slverr on mapped register");
  AST_PINS_OFF: assert property (!en_ff && !$past(en_ff, 2) |->
    !transmit_clock_pin.oe && !receive_data_pin.oe) else $error("pin driven while off");
  AST_IDLE_HIGH: assert property (!en_ff && !$past(en_ff, 2) |->
    transmit_clock_pin.o && receive_data_pin.o) else $error("pin low while off");
  AST_ASYNC_OE: assert property (en_ff && !sync_ff && $past(en_ff, 2) &&
    !$past(sync_ff, 2) |-> transmit_clock_pin.oe && !receive_data_pin.oe)
    else $error("async pin directions wrong");
  AST_FLAGS_OFF: assert property (s_acc ##0 paddr == RXCS_OFFSET && !en_ff &&
    !$past(en_ff, 3) |-> prdata[2:1] == 2'b00) else $error("flags set while off");
  AST_TX_BUSY: assert property (s_acc ##0 paddr == TXCS_OFFSET && en_ff && !sync_ff &&
    !$past(transmit_clock_pin.o) |-> !prdata[TSRE_BIT]) else $error("empty while sending");
endmodule // spcs_sva
bind spcs_top spcs_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .transmit_clock_pin, .receive_data_pin);
`default_nettype wire

// >>> sim/spcs_peer.sv
// Asynchronous serial peer: sends and captures frames.
// Assumes tasks are entered just after a rising pclk edge.
`default_nettype none
module spcs_peer #(
  parameter int BIT = 16
) (
  // Clock and lines
  input wire logic pclk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_line = 1'b1;
  // A zero stop bit is sent only to provoke a framing fault.
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT) @(posedge pclk);
    end
    rx_line <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic grab(input int n, output logic [8:0] d);
    d = 9'h0;
    while (tx_line !== 1'b0) @(posedge pclk);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge pclk);
      d[i] = tx_line;
    end
  endtask
endmodule // spcs_peer
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench of the serial port control block.
// Assumes divisor zero and high speed, so one bit lasts 16 clocks.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import spcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rx;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] b;
  spcs_pin_type tcp, rdp;
  int num_errors = 0, n_compared = 0, cyc = 0;
  spcs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .transmit_clock_pin_in(tcp.o), .receive_data_pin_in(rx),
    .transmit_clock_pin(tcp), .receive_data_pin(rdp));
  spcs_peer #(.BIT(16)) peer (.pclk, .tx_line(tcp.o), .rx_line(rx));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Polls until the shift register reads empty after having read busy.
  task automatic drain();
    logic seen;
    seen = 1'b0;
    do begin
      apb(1'b0, TXCS_OFFSET, 32'h0);
      if (rd[TSRE_BIT] === 1'b0) seen = 1'b1;
    end while (rd[TSRE_BIT] !== 1'b1 || !seen);
  endtask
  task automatic tx_one(input logic [31:0] ctl, input logic [31:0] d, input int n);
    apb(1'b1, TXCS_OFFSET, ctl);
    fork peer.grab(n, b); join_none
    apb(1'b1, DATA_OFFSET, d);
    drain();
  endtask
  task automatic t_regs();
    rdc(TXCS_OFFSET, 32'h02);
    chk({30'h0, tcp.oe, rdp.oe}, 32'h0);
    apb(1'b1, TXCS_OFFSET, 32'hf5);
    rdc(TXCS_OFFSET, 32'hf7);
    rdc(8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("regs test done");
  endtask
  task automatic t_tx();
    int n;
    apb(1'b1, BAUD_OFFSET, 32'h0);
    apb(1'b1, TXCS_OFFSET, 32'h24);
    apb(1'b1, RXCS_OFFSET, 32'h90);
    tx_one(32'h24, 32'ha5, 8);
    chk({23'h0, b}, 32'ha5);
    tx_one(32'h65, 32'h3c, 9);
    chk({23'h0, b}, 32'h13c);
    apb(1'b1, TXCS_OFFSET, 32'h2c);
    apb(1'b1, DATA_OFFSET, 32'h55);
    while (tcp.o !== 1'b0) @(posedge pclk);
    n = 0;
    while (tcp.o === 1'b0) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 32'd192);
    drain();
    rdc(TXCS_OFFSET, 32'h26);
    $display("transmit test done");
  endtask
  task automatic t_rx();
    peer.send(8'h96, 1'b1);
    repeat (40) @(posedge pclk);
    rdc(DATA_OFFSET, 32'h96);
    rdc(RXCS_OFFSET, 32'h90);
    peer.send(8'h11, 1'b1);
    peer.send(8'h22, 1'b1);
    repeat (40) @(posedge pclk);
    rdc(RXCS_OFFSET, 32'h92);
    apb(1'b1, RXCS_OFFSET, 32'h80);
    rdc(RXCS_OFFSET, 32'h80);
    apb(1'b1, RXCS_OFFSET, 32'h90);
    rdc(DATA_OFFSET, 32'h11);
    peer.send(8'h5a, 1'b0);
    repeat (40) @(posedge pclk);
    rdc(RXCS_OFFSET, 32'h94);
    $display("receive test done");
  endtask
  task automatic t_sync();
    logic [7:0] s;
    apb(1'b1, RXCS_OFFSET, 32'h80);
    apb(1'b1, BAUD_OFFSET, 32'h2);
    apb(1'b1, TXCS_OFFSET, 32'hb0);
    apb(1'b1, DATA_OFFSET, 32'h5a);
    for (int i = 0; i < 8; i++) begin
      @(posedge tcp.o);
      s[i] = rdp.o;
    end
    chk({24'h0, s}, 32'h5a);
    chk({30'h0, tcp.oe, rdp.oe}, 32'h3);
    drain();
    apb(1'b1, RXCS_OFFSET, 32'h0);
    rdc(RXCS_OFFSET, 32'h0);
    rdc(RXCS_OFFSET, 32'h0);
    $display("sync test done");
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tx();
    t_rx();
    t_sync();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
